// ### verilog/chiu_top.sv
// Interrupt gathering, prioritising, sanity and bus response timers
`timescale 1ns/10ps
`default_nettype none
module chiu_top
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        parity_read,
  input  wire logic        parity_err,
  input  wire logic        paddle_board_sc_irq,
  input  wire logic        paddle_board_host_irq,
  input  wire logic        paddle_board_term_irq,
  input  wire logic        activity_lead,
  input  wire logic        frame_pulse,
  input  wire logic [3:0]  cell_write,
  input  wire logic        bus_start,
  input  wire logic        bus_agent_ack,
  output logic             bus_error,
  input  wire logic        irq_ack,
  output logic      [2:0]  irq_level,
  output logic             irq_pending,
  output logic             sanity_reset
);
  // Pin synchronisers, two flops before any use
  logic [7:0] sync1_r;
  logic [7:0] sync2_r;
  logic [7:0] pins;
  assign pins = {cell_write, frame_pulse, activity_lead,
                 paddle_board_sc_irq | paddle_board_host_irq | paddle_board_term_irq,
                 1'b0};
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1_r <= 8'h00;
      sync2_r <= 8'h00;
    end
    else
    begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end
  wire logic       pb_s   = sync2_r[1];
  wire logic       act_s  = sync2_r[2];
  wire logic       fp_s   = sync2_r[3];
  wire logic [3:0] cell_s = sync2_r[7:4];
  function automatic logic wr_at(input logic [3:0] a);
    wr_at = reg_wr && (reg_addr == a);
  endfunction
  // Main state group
  logic [2:0]  ctrl_r,     ctrl_nxt;
  logic [7:0]  pi_r,       pi_nxt;
  logic        act_d_r,    act_d_nxt;
  logic        fp_d_r,     fp_d_nxt;
  logic [3:0]  cell_d_r,   cell_d_nxt;
  logic [13:0] fwin_r,     fwin_nxt;
  logic        fp_seen_r,  fp_seen_nxt;
  logic        stage_r,    stage_nxt;
  logic [12:0] san_cnt_r,  san_cnt_nxt;
  logic [6:0]  lvl_r,      lvl_nxt;
  logic [31:0] gpt_load_r, gpt_load_nxt;
  logic [31:0] gpt_cnt_r,  gpt_cnt_nxt;
  logic [31:0] sch_load_r, sch_load_nxt;
  logic [31:0] sch_cnt_r,  sch_cnt_nxt;
  logic        san_rst_r,  san_rst_nxt;
  logic [2:0]  ev_wp_r,    ev_wp_nxt;
  logic        ev_we;
  logic [7:0]  ev_wdata;
  logic        bus_to;
  always_comb
  begin
    ctrl_nxt     = ctrl_r;
    pi_nxt       = pi_r;
    act_d_nxt    = act_s;
    fp_d_nxt     = fp_s;
    cell_d_nxt   = cell_s;
    fwin_nxt     = fwin_r;
    fp_seen_nxt  = fp_seen_r;
    stage_nxt    = stage_r;
    san_cnt_nxt  = san_cnt_r;
    lvl_nxt      = lvl_r;
    gpt_load_nxt = gpt_load_r;
    gpt_cnt_nxt  = gpt_cnt_r;
    sch_load_nxt = sch_load_r;
    sch_cnt_nxt  = sch_cnt_r;
    san_rst_nxt  = 1'b0;
    ev_wp_nxt    = ev_wp_r;
    if (wr_at(chiu_pkg::ADDR_CTRL))
      ctrl_nxt = reg_wdata[2:0];
    if (wr_at(chiu_pkg::ADDR_GPT_LOAD))
    begin
      gpt_load_nxt = reg_wdata;
      gpt_cnt_nxt  = reg_wdata;
    end
    if (wr_at(chiu_pkg::ADDR_SCH_LOAD))
    begin
      sch_load_nxt = reg_wdata;
      sch_cnt_nxt  = reg_wdata;
    end
    if (wr_at(chiu_pkg::ADDR_PERIPH))
      pi_nxt = pi_r & ~reg_wdata[7:0];
    if (wr_at(chiu_pkg::ADDR_STATUS))
      lvl_nxt = lvl_r & ~reg_wdata[6:0];
    if (act_s != act_d_r)
      pi_nxt[chiu_pkg::PI_ACT_SWITCH] = 1'b1;
    if (fp_s && !fp_d_r)
    begin
      fwin_nxt    = 14'd0;
      fp_seen_nxt = 1'b1;
    end
    else if (fp_seen_r)
    begin
      if (fwin_r == 14'(chiu_pkg::FRAME_WIN_CYC - 1))
      begin
        pi_nxt[chiu_pkg::PI_FRAME_LOSS] = 1'b1;
        fp_seen_nxt                     = 1'b0;
      end
      else
        fwin_nxt = fwin_r + 14'd1;
    end
    if (|(cell_s & ~cell_d_r))
      pi_nxt[chiu_pkg::PI_LINK_CELL] = 1'b1;
    // Two-stage watchdog, kick restarts stage one
    if (!ctrl_nxt[chiu_pkg::CTRL_SAN_EN] ||
        (wr_at(chiu_pkg::ADDR_SANITY) && reg_wdata == chiu_pkg::SANITY_KEY))
    begin
      stage_nxt   = 1'b0;
      san_cnt_nxt = 13'd0;
    end
    else if (san_cnt_r == 13'(chiu_pkg::SANITY_STAGE_CYC - 1))
    begin
      san_cnt_nxt = 13'd0;
      if (!stage_r)
      begin
        stage_nxt = 1'b1;
        lvl_nxt[0] = 1'b1;
      end
      else
      begin
        stage_nxt   = 1'b0;
        san_rst_nxt = 1'b1;
      end
    end
    else
      san_cnt_nxt = san_cnt_r + 13'd1;
    if (parity_read && parity_err)
      lvl_nxt[1] = 1'b1;
    if (ctrl_r[chiu_pkg::CTRL_GPT_EN] && !wr_at(chiu_pkg::ADDR_GPT_LOAD))
    begin
      if (gpt_cnt_r == 32'h0000_0000)
      begin
        gpt_cnt_nxt = gpt_load_r;
        lvl_nxt[3]  = 1'b1;
      end
      else
        gpt_cnt_nxt = gpt_cnt_r - 32'h0000_0001;
    end
    if (ctrl_r[chiu_pkg::CTRL_SCH_EN] && !wr_at(chiu_pkg::ADDR_SCH_LOAD))
    begin
      if (sch_cnt_r == 32'h0000_0000)
      begin
        sch_cnt_nxt = sch_load_r;
        lvl_nxt[4]  = 1'b1;
      end
      else
        sch_cnt_nxt = sch_cnt_r - 32'h0000_0001;
    end
    lvl_nxt[2] = 1'b0;
    // Paddle board level follows its pins
    lvl_nxt[5] = pb_s;
    // Level seven held while any flag latched
    lvl_nxt[6] = |(pi_nxt & chiu_pkg::PI_USED_MASK);
    if (pi_nxt != pi_r)
      ev_wp_nxt = ev_wp_r + 3'd1;
  end
  // Log each change of the peripheral register; software can read only the write pointer
  assign ev_we    = (pi_nxt != pi_r);
  assign ev_wdata = pi_nxt;

  // Reset returns all state, sanity disabled
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_r     <= 3'b000;
      pi_r       <= 8'h00;
      act_d_r    <= 1'b0;
      fp_d_r     <= 1'b0;
      cell_d_r   <= 4'h0;
      fwin_r     <= 14'd0;
      fp_seen_r  <= 1'b0;
      stage_r    <= 1'b0;
      san_cnt_r  <= 13'd0;
      lvl_r      <= 7'h00;
      gpt_load_r <= 32'h0000_0000;
      gpt_cnt_r  <= 32'h0000_0000;
      sch_load_r <= 32'h0000_0000;
      sch_cnt_r  <= 32'h0000_0000;
      san_rst_r  <= 1'b0;
      ev_wp_r    <= 3'd0;
    end
    else
    begin
      ctrl_r     <= ctrl_nxt;
      pi_r       <= pi_nxt;
      act_d_r    <= act_d_nxt;
      fp_d_r     <= fp_d_nxt;
      cell_d_r   <= cell_d_nxt;
      fwin_r     <= fwin_nxt;
      fp_seen_r  <= fp_seen_nxt;
      stage_r    <= stage_nxt;
      san_cnt_r  <= san_cnt_nxt;
      lvl_r      <= lvl_nxt;
      gpt_load_r <= gpt_load_nxt;
      gpt_cnt_r  <= gpt_cnt_nxt;
      sch_load_r <= sch_load_nxt;
      sch_cnt_r  <= sch_cnt_nxt;
      san_rst_r  <= san_rst_nxt;
      ev_wp_r    <= ev_wp_nxt;
    end
  end
  assign sanity_reset = san_rst_r;
  // Bus response timer group
  chiu_pkg::chiu_bus_state_t bst_r, bst_nxt;
  logic [6:0] bcnt_r, bcnt_nxt;
  always_comb
  begin
    bst_nxt  = bst_r;
    bcnt_nxt = bcnt_r;
    bus_to   = 1'b0;
    case (bst_r)
      chiu_pkg::BUS_IDLE:
      begin
        bcnt_nxt = 7'd0;
        if (bus_start && !bus_agent_ack)
          bst_nxt = chiu_pkg::BUS_WAIT;
      end
      chiu_pkg::BUS_WAIT:
      begin
        if (bus_agent_ack)
          bst_nxt = chiu_pkg::BUS_IDLE;
        else if (bcnt_r == 7'(chiu_pkg::BUS_TIMEOUT_CYC - 1))
          bst_nxt = chiu_pkg::BUS_TERM;
        else
          bcnt_nxt = bcnt_r + 7'd1;
      end
      chiu_pkg::BUS_TERM:
      begin
        bus_to  = 1'b1;
        bst_nxt = chiu_pkg::BUS_IDLE;
      end
      default:
        bst_nxt = chiu_pkg::BUS_IDLE;
    endcase
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bst_r  <= chiu_pkg::BUS_IDLE;
      bcnt_r <= 7'd0;
    end
    else
    begin
      bst_r  <= bst_nxt;
      bcnt_r <= bcnt_nxt;
    end
  end
  assign bus_error = bus_to;
  logic [2:0] enc;
  always_comb
  begin
    enc = 3'd0;
    for (int i = chiu_pkg::NUM_LEVELS - 1; i >= 0; i--)
      if (lvl_r[i])
        enc = 3'(i + 1);
  end
  // Ack of level seven leaves the peripheral register for polling
  assign irq_level   = enc;
  assign irq_pending = (enc != 3'd0) && !irq_ack;
  // Event log memory
  logic [7:0] ev_rdata;
  chiu_evlog_mem u_evlog
  (
    .mclk  (mclk),
    .we    (ev_we),
    .waddr (ev_wp_r),
    .wdata (ev_wdata),
    .raddr (reg_wdata[2:0]),
    .rdata (ev_rdata)
  );
  // Read port, data one cycle after the strobe
  logic        rd_r;
  logic [31:0] rd_hold_r, rd_hold_nxt;
  always_comb
  begin
    case (reg_addr)
      chiu_pkg::ADDR_CTRL:     rd_hold_nxt = {29'd0, ctrl_r};
      chiu_pkg::ADDR_STATUS:   rd_hold_nxt = {24'd0, stage_r, lvl_r};
      chiu_pkg::ADDR_PERIPH:   rd_hold_nxt = {24'd0, pi_r};
      chiu_pkg::ADDR_GPT_LOAD: rd_hold_nxt = gpt_cnt_r;
      chiu_pkg::ADDR_SCH_LOAD: rd_hold_nxt = sch_cnt_r;
      chiu_pkg::ADDR_ACK:      rd_hold_nxt = {29'd0, enc};
      chiu_pkg::ADDR_BUSERR:   rd_hold_nxt = {29'd0, bst_r};
      chiu_pkg::ADDR_EVLOG:    rd_hold_nxt = {29'd0, ev_wp_r};
      default:                 rd_hold_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rd_r      <= 1'b0;
      rd_hold_r <= 32'h0000_0000;
    end
    else
    begin
      rd_r      <= reg_rd;
      rd_hold_r <= rd_hold_nxt;
    end
  end
  assign reg_rdata = !rd_r ? 32'h0000_0000 : rd_hold_r;
  logic unused_ok;
  assign unused_ok = ^{ev_rdata, sync2_r[0]};
endmodule
`default_nettype wire

// ### verilog/chiu_pkg.sv
// Constants for the channel handler interrupt unit
package chiu_pkg;
  // Register indices (byte address = 4 * index)
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_STATUS   = 4'h1;
  localparam logic [3:0] ADDR_PERIPH   = 4'h2;
  localparam logic [3:0] ADDR_SANITY   = 4'h3;
  localparam logic [3:0] ADDR_GPT_LOAD = 4'h4;
  localparam logic [3:0] ADDR_SCH_LOAD = 4'h5;
  localparam logic [3:0] ADDR_ACK      = 4'h6;
  localparam logic [3:0] ADDR_BUSERR   = 4'h7;
  localparam logic [3:0] ADDR_EVLOG    = 4'h8;
  localparam logic [3:0] EVLOG_DEPTH   = 4'h8;
  // Control register bit positions
  localparam int CTRL_SAN_EN  = 0;
  localparam int CTRL_GPT_EN  = 1;
  localparam int CTRL_SCH_EN  = 2;
  // Peripheral interrupt register bit positions
  localparam int PI_ACT_SWITCH = 0;
  localparam int PI_FRAME_LOSS = 1;
  localparam int PI_LINK_CELL  = 2;
  localparam logic [7:0] PI_USED_MASK = 8'h07;
  localparam int NUM_LEVELS = 7;
  localparam int NUM_CELLS  = 4;
  // Sanity restart key
  localparam logic [31:0] SANITY_KEY = 32'h0000_005a;
  // Timing (50 MHz clock)
  localparam int CLK_MHZ          = 50;
  localparam int SANITY_STAGE_US  = 100;
  localparam int SANITY_STAGE_CYC = SANITY_STAGE_US * CLK_MHZ;
  localparam int BUS_TIMEOUT_US   = 2;
  localparam int BUS_TIMEOUT_CYC  = BUS_TIMEOUT_US * CLK_MHZ;
  localparam int FRAME_PERIOD_US  = 125;
  localparam int FRAME_WIN_CYC    = (FRAME_PERIOD_US * CLK_MHZ * 5) / 4;
  // Bus access states
  typedef enum logic [2:0]
  {
    BUS_IDLE = 3'b001,
    BUS_WAIT = 3'b010,
    BUS_TERM = 3'b100
  } chiu_bus_state_t;
endpackage

// ### verilog/chiu_evlog_mem.sv
// Small event log memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module chiu_evlog_mem
(
  input  wire logic       mclk,
  input  wire logic       we,
  input  wire logic [2:0] waddr,
  input  wire logic [7:0] wdata,
  input  wire logic [2:0] raddr,
  output logic      [7:0] rdata
);
  logic [7:0] mem [0:7];
  // No reset: contents are only meaningful once written
  always_ff @(posedge mclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// ### bench/chiu_chk.sv
// Port assertions for the channel handler interrupt unit
`timescale 1ns/10ps
`default_nettype none
module chiu_chk
(
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       parity_read,
  input wire logic       parity_err,
  input wire logic       paddle_board_sc_irq,
  input wire logic       paddle_board_host_irq,
  input wire logic       paddle_board_term_irq,
  input wire logic       activity_lead,
  input wire logic [3:0] cell_write,
  input wire logic       bus_start,
  input wire logic       bus_agent_ack,
  input wire logic       bus_error,
  input wire logic       irq_ack,
  input wire logic [2:0] irq_level,
  input wire logic       irq_pending,
  input wire logic       sanity_reset
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  logic        wait_r;
  logic [7:0]  wcnt_r;
  logic [15:0] cyc_r;
  logic        pb_any;
  assign pb_any = paddle_board_sc_irq | paddle_board_host_irq | paddle_board_term_irq;
  // Unanswered access age; cleared by an answer or the timeout itself
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wait_r <= 1'b0;
      wcnt_r <= 8'h0;
      cyc_r  <= 16'h0;
    end
    else
    begin
      if (cyc_r != 16'hffff)
        cyc_r <= cyc_r + 16'h1;
      if (bus_start)
      begin
        wait_r <= 1'b1;
        wcnt_r <= 8'h0;
      end
      else if (bus_agent_ack || bus_error)
        wait_r <= 1'b0;
      else if (wait_r)
        wcnt_r <= wcnt_r + 8'h1;
    end
  end
  level3_unused_a: assert property (irq_level != 3'h3)
    else $error("level three presented");
  pend_level_a: assert property (irq_pending |-> irq_level != 3'h0)
    else $error("pending without a level");
  pend_mask_a: assert property (irq_pending == ((irq_level != 3'h0) && !irq_ack))
    else $error("pending not masked by acknowledge");
  bus_window_a: assert property (bus_error |-> wait_r && (wcnt_r inside {[8'd94:8'd106]}))
    else $error("bus error at wrong time");
  bus_pulse_a: assert property (bus_error |=> !bus_error)
    else $error("bus error longer than a cycle");
  san_pulse_a: assert property (sanity_reset |=> !sanity_reset)
    else $error("sanity reset longer than a cycle");
  san_late_a: assert property (sanity_reset |-> cyc_r >= 16'd10000)
    else $error("sanity reset before two stages");
  parity_lvl_a: assert property (parity_read && parity_err |-> ##[1:4] irq_level inside {3'h1, 3'h2})
    else $error("parity error not raised");
  paddle_lvl_a: assert property (pb_any [*6] |-> irq_level inside {[3'h1:3'h6]})
    else $error("paddle board request not raised");
  act_edge_a: assert property ($changed(activity_lead) |-> ##[1:8] irq_level != 3'h0)
    else $error("activity change not raised");
  cell_edge_a: assert property ((cell_write & ~$past(cell_write)) != 4'h0 |-> ##[1:8] irq_level != 3'h0)
    else $error("cell write not raised");
  cover property (bus_error);
  cover property (sanity_reset);
  cover property (irq_level == 3'h7);
endmodule
bind chiu_top chiu_chk chiu_chk_inst
(
  .mclk(mclk), .rst(rst), .parity_read(parity_read), .parity_err(parity_err),
  .paddle_board_sc_irq(paddle_board_sc_irq), .paddle_board_host_irq(paddle_board_host_irq),
  .paddle_board_term_irq(paddle_board_term_irq), .activity_lead(activity_lead),
  .cell_write(cell_write), .bus_start(bus_start), .bus_agent_ack(bus_agent_ack),
  .bus_error(bus_error), .irq_ack(irq_ack), .irq_level(irq_level), .irq_pending(irq_pending),
  .sanity_reset(sanity_reset)
);
`default_nettype wire

// ### bench/chiu_cpu_model.sv
// Processor core model: interrupt acknowledge and a slow bus agent
`timescale 1ns/10ps
`default_nettype none
module chiu_cpu_model
(
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic irq_pending,
  input  wire logic bus_start,
  input  wire logic answer_en,
  output logic      irq_ack,
  output logic      bus_agent_ack
);
  logic [1:0] dly_r;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_ack       <= 1'b0;
      dly_r         <= 2'h0;
      bus_agent_ack <= 1'b0;
    end
    else
    begin
      irq_ack <= irq_pending && !irq_ack;
      // Agent answers three cycles late, or never when muted
      if (bus_start && answer_en)
        dly_r <= 2'h3;
      else if (dly_r != 2'h0)
        dly_r <= dly_r - 2'h1;
      bus_agent_ack <= (dly_r == 2'h1);
    end
  end
endmodule
`default_nettype wire

// ### bench/chiu_top_tb.sv
// Register level testbench for the channel handler interrupt unit
`timescale 1ns/10ps
`default_nettype none
module chiu_top_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        parity_read = 1'b0;
  logic        parity_err = 1'b0;
  logic [2:0]  pb = 3'h0;
  logic        activity_lead = 1'b0;
  logic        frame_pulse = 1'b0;
  logic [3:0]  cell_write = 4'h0;
  logic        bus_start = 1'b0;
  logic        answer_en = 1'b1;
  logic        bus_agent_ack, bus_error, irq_ack, irq_pending, sanity_reset;
  logic [2:0]  irq_level;
  int          n_errors = 0;
  int          compares = 0;
  int          berr_n = 0;
  int          i, k;
  always #10 mclk = ~mclk;
  chiu_top chiu_top_inst
  (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .parity_read(parity_read),
    .parity_err(parity_err), .paddle_board_sc_irq(pb[0]), .paddle_board_host_irq(pb[1]),
    .paddle_board_term_irq(pb[2]), .activity_lead(activity_lead),
    .frame_pulse(frame_pulse), .cell_write(cell_write), .bus_start(bus_start),
    .bus_agent_ack(bus_agent_ack), .bus_error(bus_error), .irq_ack(irq_ack),
    .irq_level(irq_level), .irq_pending(irq_pending), .sanity_reset(sanity_reset)
  );
  chiu_cpu_model chiu_cpu_model_inst
  (
    .mclk(mclk), .rst(rst), .irq_pending(irq_pending), .bus_start(bus_start),
    .answer_en(answer_en), .irq_ack(irq_ack), .bus_agent_ack(bus_agent_ack)
  );
  always @(posedge mclk)
    if (bus_error === 1'b1)
      berr_n = berr_n + 1;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  task automatic lvl(input logic [2:0] e);
    chk({29'h0, irq_level}, {29'h0, e});
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Run needs about 45k cycles; cut off at 90k
  initial
  begin
    #1800000;
    n_errors++;
    conclude();
  end
  initial
  begin
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    rd(chiu_pkg::ADDR_CTRL, 32'h0);
    rd(chiu_pkg::ADDR_STATUS, 32'h0);
    rd(chiu_pkg::ADDR_PERIPH, 32'h0);
    wr(4'hf, 32'hffff_ffff);
    rd(4'hf, 32'h0);
    @(posedge mclk);
    parity_err <= 1'b1;
    @(posedge mclk);
    parity_read <= 1'b1;
    @(posedge mclk);
    parity_err <= 1'b0;
    parity_read <= 1'b0;
    cyc(4);
    rd(chiu_pkg::ADDR_STATUS, 32'h2);
    lvl(3'h2);
    rd(chiu_pkg::ADDR_ACK, 32'h2);
    wr(chiu_pkg::ADDR_STATUS, 32'h2);
    rd(chiu_pkg::ADDR_STATUS, 32'h0);
    wr(chiu_pkg::ADDR_GPT_LOAD, 32'd9);
    wr(chiu_pkg::ADDR_SCH_LOAD, 32'd19);
    rd(chiu_pkg::ADDR_GPT_LOAD, 32'd9);
    rd(chiu_pkg::ADDR_SCH_LOAD, 32'd19);
    wr(chiu_pkg::ADDR_CTRL, 32'h6);
    cyc(60);
    wr(chiu_pkg::ADDR_CTRL, 32'h0);
    cyc(2);
    rd(chiu_pkg::ADDR_STATUS, 32'h18);
    lvl(3'h4);
    wr(chiu_pkg::ADDR_STATUS, 32'h8);
    cyc(2);
    lvl(3'h5);
    wr(chiu_pkg::ADDR_STATUS, 32'h10);
    cyc(2);
    lvl(3'h0);
    for (i = 0; i < 3; i++)
    begin
      @(posedge mclk);
      pb <= 3'h1 << i;
      cyc(6);
      lvl(3'h6);
      rd(chiu_pkg::ADDR_STATUS, 32'h20);
      pb <= 3'h0;
      cyc(6);
      lvl(3'h0);
    end
    // Frame status is not judged until the first frame pulse
    // Two lead edges then each cell; flags must survive until cleared
    for (i = 0; i < 6; i++)
    begin
      if (i < 2)
        activity_lead <= ~activity_lead;
      else
        cell_write <= 4'h1 << (i - 2);
      cyc(30);
      lvl(3'h7);
      rd(chiu_pkg::ADDR_PERIPH, (i < 2) ? 32'h1 : 32'h4);
      cell_write <= 4'h0;
      wr(chiu_pkg::ADDR_PERIPH, 32'hff);
      cyc(8);
      rd(chiu_pkg::ADDR_PERIPH, 32'h0);
      lvl(3'h0);
    end
    activity_lead <= ~activity_lead;
    pb <= 3'h1;
    cyc(8);
    lvl(3'h6);
    pb <= 3'h0;
    cyc(6);
    lvl(3'h7);
    wr(chiu_pkg::ADDR_PERIPH, 32'h1);
    @(posedge mclk);
    bus_start <= 1'b1;
    @(posedge mclk);
    bus_start <= 1'b0;
    cyc(150);
    chk(berr_n, 0);
    answer_en <= 1'b0;
    @(posedge mclk);
    bus_start <= 1'b1;
    @(posedge mclk);
    bus_start <= 1'b0;
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end while (bus_error !== 1'b1 && k < 200);
    chk(k >= 98 && k <= 102, 1);
    cyc(20);
    chk(berr_n, 1);
    rd(chiu_pkg::ADDR_BUSERR, 32'h1);
    wr(chiu_pkg::ADDR_CTRL, 32'h1);
    for (i = 0; i < 3; i++)
    begin
      cyc(4000);
      wr(chiu_pkg::ADDR_SANITY, chiu_pkg::SANITY_KEY);
    end
    lvl(3'h0);
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end while (irq_level !== 3'h1 && k < 5200);
    lvl(3'h1);
    rd(chiu_pkg::ADDR_STATUS, 32'h81);
    k = 0;
    do
    begin
      cyc(1);
      k++;
    end while (sanity_reset !== 1'b1 && k < 5200);
    chk(k >= 4990 && k <= 5010, 1);
    wr(chiu_pkg::ADDR_CTRL, 32'h0);
    // Pulses 6000 cycles apart stay inside the window, then they stop
    for (i = 0; i < 3; i++)
    begin
      frame_pulse <= 1'b1;
      cyc(2);
      frame_pulse <= 1'b0;
      cyc(6000);
    end
    rd(chiu_pkg::ADDR_PERIPH, 32'h0);
    cyc(2000);
    rd(chiu_pkg::ADDR_PERIPH, 32'h2);
    wr(chiu_pkg::ADDR_PERIPH, 32'h2);
    rd(chiu_pkg::ADDR_PERIPH, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
